// ### plro_cmds.sv
// Loop and rail order command bank with gap control and sequencer.
// Assumes a framing engine giving command-level strobes on clk_sys.
// Behaviour
// - Hold 7-bit tempco factor, bits 6:0
// - Resistance = gain*(1+tc*1e-4*(T-25))
// - Bit 7 picks external sensors if ext_sense_en is high, else internal
// - Bits 15:8: signed high-to-low gap ns
// - Bits 7:0: signed low-to-high gap ns
// - Adaptive maximum gap defaults to 60 ns
// - Gap write then mode write sets maximums
// - Adaptive off: use written gaps exactly
// - Bits 14:8: minimum high-to-low gap, x2 ns
// - Bits 6:0: minimum low-to-high gap, x2 ns
// - Bit 15 freezes high-to-low gap
// - Bit 7 freezes low-to-high gap
// - Loop block: residual 23:16, gain 15:0
// - Loop block bit 24 enables fast loop
// - Prequel: enable after request and power-good
// - Sequel power-down disables output with delay
// - Bits 12:8 hold prequel rail id
// - Bits 4:0 hold sequel rail id
// - Bit 15 enables prequel waiting
// - Bit 7 enables sequel power-down following
`default_nettype none
module plro_cmds
  import plro_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               cmd_wr,
  input  wire logic               cmd_rd,
  input  wire logic [7:0]         cmd_code,
  input  wire logic [31:0]        cmd_wdata,
  output logic      [31:0]        cmd_rdata,
  output logic                    cmd_ack,
  output logic                    cmd_unsupported,
  input  wire logic [15:0]        current_cal_gain,
  input  wire logic signed [11:0] temp_int,
  input  wire logic signed [11:0] temp_ext0,
  input  wire logic signed [11:0] temp_ext1,
  input  wire logic               ext_sense_en,
  output logic signed [23:0]      sense_resistance0,
  output logic signed [23:0]      sense_resistance1,
  input  wire logic               adapt_active,
  input  wire logic [1:0]         adapt_inc,
  input  wire logic [1:0]         adapt_dec,
  output logic signed [7:0]       gap_lh_ns,
  output logic signed [7:0]       gap_hl_ns,
  output logic                    fast_loop_response_en,
  output logic [7:0]              fast_loop_residual,
  output logic [15:0]             fast_loop_gain,
  input  wire logic               on_request,
  input  wire logic               group_comm_bus_evt,
  input  wire logic               group_comm_bus_kind,
  input  wire logic [4:0]         group_comm_bus_id,
  input  wire logic [15:0]        toff_cycles,
  output logic                    output_enable
);
  // ==========================================================
  // Command storage
  logic [7:0]  tempco;        // Temperature correction byte
  logic [15:0] gap_cfg;       // Written switch gaps
  logic [15:0] gap_mode;      // Mode bits and minimums
  logic [31:0] loop_cfg;      // Fast loop settings
  logic [15:0] order;         // Rail order links
  logic        last_was_gap;  // Previous write hit the gap command
  logic [7:0]  gap_max [2];   // Adaptive maximums, 0 = L-H, 1 = H-L
  logic signed [7:0] gap [2]; // Applied gaps
  logic        known;         // Code decodes to a held command

  always_comb
  begin
    known = (cmd_code == CMD_TEMPCO) || (cmd_code == CMD_GAP) ||
            (cmd_code == CMD_GAPMODE) || (cmd_code == CMD_LOOP) ||
            (cmd_code == CMD_ORDER);
  end

  // Register writes keep only field bits
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tempco   <= '0;
      gap_cfg  <= RST_GAP;
      gap_mode <= RST_GAPMODE;
      loop_cfg <= '0;
      order    <= '0;
    end
    else if (cmd_wr)
    begin
      if (cmd_code == CMD_TEMPCO)
        tempco <= cmd_wdata[7:0] & MSK_TEMPCO[7:0];
      else if (cmd_code == CMD_GAP)
        gap_cfg <= cmd_wdata[15:0] & MSK_GAP[15:0];
      else if (cmd_code == CMD_GAPMODE)
        gap_mode <= cmd_wdata[15:0] & MSK_GAPMODE[15:0];
      else if (cmd_code == CMD_LOOP)
        loop_cfg <= cmd_wdata & MSK_LOOP;
      else if (cmd_code == CMD_ORDER)
        order <= cmd_wdata[15:0] & MSK_ORDER[15:0];
    end
  end

  // Tracks whether the last write was the gap command
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      last_was_gap <= 1'b0;
    else if (cmd_wr)
      last_was_gap <= (cmd_code == CMD_GAP);
  end

  // Read answer and acknowledge, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmd_rdata       <= '0;
      cmd_ack         <= 1'b0;
      cmd_unsupported <= 1'b0;
    end
    else
    begin
      cmd_ack         <= (cmd_wr || cmd_rd) && known;
      cmd_unsupported <= (cmd_wr || cmd_rd) && !known;
      if (cmd_rd)
      begin
        if (cmd_code == CMD_TEMPCO)
          cmd_rdata <= {24'h000000, tempco};
        else if (cmd_code == CMD_GAP)
          cmd_rdata <= {16'h0000, gap_cfg};
        else if (cmd_code == CMD_GAPMODE)
          cmd_rdata <= {16'h0000, gap_mode};
        else if (cmd_code == CMD_LOOP)
          cmd_rdata <= loop_cfg;
        else if (cmd_code == CMD_ORDER)
          cmd_rdata <= {16'h0000, order};
        else
          cmd_rdata <= '0;
      end
    end
  end

  // ==========================================================
  // Fast loop outputs come straight from the stored block
  assign fast_loop_response_en = loop_cfg[LOOP_EN_BIT];
  assign fast_loop_residual    = loop_cfg[RES_LSB +: 8];
  assign fast_loop_gain        = loop_cfg[15:0];

  // ==========================================================
  // Sense resistance per phase; internal sensor serves both unless bit 7 and ext_sense_en pick external
  logic signed [23:0] res [2];
  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_sense
      logic signed [11:0] t_sel; // Selected temperature
      logic signed [12:0] d_t;   // Offset from reference
      logic signed [37:0] prod;  // gain * tc * dT
      logic signed [37:0] corr;  // Scaled correction
      always_comb
      begin
        // External only when software enabled external sensing
        if (tempco[TC_SRC_BIT] && ext_sense_en)
          t_sel = (s == 0) ? temp_ext0 : temp_ext1;
        else
          t_sel = temp_int;
        d_t  = 13'(t_sel) - $signed(T_REF_C);
        prod = 38'($signed({1'b0, current_cal_gain}) *
                   $signed({1'b0, tempco[6:0]}) * d_t);
        corr = prod / $signed(TC_SCALE);
      end
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          res[s] <= '0;
        else
          res[s] <= 24'($signed({1'b0, current_cal_gain}) + corr);
      end
    end
  endgenerate
  assign sense_resistance0 = res[0];
  assign sense_resistance1 = res[1];

  // ==========================================================
  // Switch gaps: channel 0 low-to-high, channel 1 high-to-low
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_gap
      logic signed [7:0] wr_gap;  // Written gap
      logic signed [7:0] min_gap; // Minimum, value x 2 ns
      logic              freeze;  // Hold current gap
      always_comb
      begin
        wr_gap  = gap_cfg[c*HL_LSB +: 8];
        min_gap = {gap_mode[c*HL_LSB + 6 -: 7], 1'b0};
        freeze  = gap_mode[c*HL_LSB + 7];
      end
      // Maximum loads from gap command on a gap-then-mode write
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          gap_max[c] <= GAP_MAX_DEF;
        else if (cmd_wr && cmd_code == CMD_GAPMODE && last_was_gap)
          gap_max[c] <= wr_gap;
      end
      // Adaptive stepping within the minimum and maximum
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          gap[c] <= RST_GAP[c*HL_LSB +: 8];
        else if (!adapt_active)
          gap[c] <= wr_gap;
        else if (freeze)
          gap[c] <= gap[c];
        else if (adapt_inc[c] && gap[c] < $signed(gap_max[c]))
          gap[c] <= gap[c] + 8'sh01;
        else if (adapt_dec[c] && gap[c] > min_gap)
          gap[c] <= gap[c] - 8'sh01;
      end
    end
  endgenerate
  assign gap_lh_ns = gap[0];
  assign gap_hl_ns = gap[1];

  // ==========================================================
  // Rail ordering over the group bus
  plro_seq_t   state;    // Sequencer state
  logic        pre_pg;   // Prequel rail reported power-good
  logic [15:0] stop_cnt; // Turn-off delay count
  logic        pre_hit;  // Event came from the prequel rail
  logic        seq_pd;   // Sequel rail reported power-down

  always_comb
  begin
    pre_hit = group_comm_bus_evt && group_comm_bus_id == order[PRE_ID_LSB +: 5];
    seq_pd  = group_comm_bus_evt && group_comm_bus_kind == EVT_PDOWN &&
              group_comm_bus_id == order[4:0] && order[SEQ_EN_BIT];
  end

  // Power-good memory of the prequel rail, set wins
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      pre_pg <= 1'b0;
    else if (pre_hit && group_comm_bus_kind == EVT_PGOOD)
      pre_pg <= 1'b1;
    else if (pre_hit)
      pre_pg <= 1'b0;
  end

  // Sequencer
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state         <= SEQ_OFF;
      stop_cnt      <= '0;
      output_enable <= 1'b0;
    end
    else
    begin
      case (state)
        SEQ_OFF:
          if (on_request)
            state <= SEQ_WAIT;
        SEQ_WAIT:
          // Off request wins over a waiting start
          if (!on_request)
            state <= SEQ_OFF;
          else if (!order[PRE_EN_BIT] || pre_pg)
          begin
            state         <= SEQ_ON;
            output_enable <= 1'b1;
          end
        SEQ_ON:
          if (!on_request || seq_pd)
          begin
            state    <= SEQ_STOP;
            stop_cnt <= toff_cycles;
          end
        SEQ_STOP:
          // Programmed turn-off delay runs down, then output drops
          if (stop_cnt == '0)
          begin
            state         <= SEQ_OFF;
            output_enable <= 1'b0;
          end
          else
            stop_cnt <= stop_cnt - 16'h0001;
        default:
          state <= SEQ_OFF;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_tempco_store: assert property (cmd_wr && cmd_code == CMD_TEMPCO |=>
    tempco == ($past(cmd_wdata[7:0]) & MSK_TEMPCO[7:0]))
    else $error("tempco not stored");
  a_order_zero: assert property (order[14:13] == 2'b00 && order[6:5] == 2'b00)
    else $error("order reserved bits set");
  a_loop_zero: assert property (loop_cfg[31:25] == 7'h00)
    else $error("loop reserved bits set");
  a_gap_fixed: assert property (!adapt_active |=> gap_hl_ns == $past(gap_cfg[15:8]))
    else $error("fixed gap not applied");
  a_max_load: assert property (cmd_wr && cmd_code == CMD_GAPMODE && last_was_gap |=>
    gap_max[1] == $past(gap_cfg[15:8]) && gap_max[0] == $past(gap_cfg[7:0]))
    else $error("maximum not loaded");
  a_hl_freeze: assert property (adapt_active && gap_mode[15] && $past(adapt_active) |=>
    $stable(gap_hl_ns))
    else $error("frozen gap moved");
  a_pre_block: assert property (state == SEQ_WAIT && order[PRE_EN_BIT] && !pre_pg
    |=> !output_enable)
    else $error("output before prequel good");
  a_pre_off: assert property (state == SEQ_WAIT && on_request && !order[PRE_EN_BIT]
    |=> output_enable && state == SEQ_ON)
    else $error("waited without prequel");
  a_seq_stop: assert property (state == SEQ_ON && seq_pd |=>
    state == SEQ_STOP && output_enable && stop_cnt == $past(toff_cycles))
    else $error("sequel power-down missed");
  a_loop_en: assert property (cmd_wr && cmd_code == CMD_LOOP |=>
    fast_loop_response_en == $past(cmd_wdata[24]))
    else $error("fast loop enable wrong");

  c_turn_on: cover property (state == SEQ_WAIT ##1 state == SEQ_ON);
  c_seq_off: cover property (state == SEQ_ON && seq_pd ##[1:20] !output_enable);
  c_max_set: cover property (cmd_wr && cmd_code == CMD_GAP ##[1:5]
    cmd_wr && cmd_code == CMD_GAPMODE);
  c_bad_cmd: cover property (cmd_unsupported);
endmodule : plro_cmds
`default_nettype wire

// ### plro_pkg.sv
// Constants shared by the loop and rail order command bank.
// Assumes command codes come from an outside PMBus framing engine.
`default_nettype none
package plro_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_TEMPCO  = 8'hDC;
  localparam logic [7:0] CMD_GAP     = 8'hDD;
  localparam logic [7:0] CMD_GAPMODE = 8'hDE;
  localparam logic [7:0] CMD_LOOP    = 8'hDF;
  localparam logic [7:0] CMD_ORDER   = 8'hE0;
  // ==========================================================
  // Writable bit masks, unassigned bits stay zero
  localparam logic [31:0] MSK_TEMPCO  = 32'h0000_00FF;
  localparam logic [31:0] MSK_GAP     = 32'h0000_FFFF;
  localparam logic [31:0] MSK_GAPMODE = 32'h0000_FFFF;
  localparam logic [31:0] MSK_LOOP    = 32'h01FF_FFFF;
  localparam logic [31:0] MSK_ORDER   = 32'h0000_9F9F;
  // ==========================================================
  // Field positions
  localparam int TC_SRC_BIT  = 7;
  localparam int HL_LSB      = 8;
  localparam int LOOP_EN_BIT = 24;
  localparam int RES_LSB     = 16;
  localparam int PRE_EN_BIT  = 15;
  localparam int SEQ_EN_BIT  = 7;
  localparam int PRE_ID_LSB  = 8;
  // ==========================================================
  // Reset values and arithmetic constants
  localparam logic [15:0] RST_GAP     = 16'h3C3C;
  localparam logic [7:0]  GAP_MAX_DEF = 8'h3C;
  localparam logic [15:0] RST_GAPMODE = 16'h0000;
  localparam logic [12:0] T_REF_C     = 13'h0019;
  localparam logic [37:0] TC_SCALE    = 38'h00_0000_2710;
  // ==========================================================
  // Sequencer states and group bus event kinds
  typedef enum logic [3:0] {
    SEQ_OFF  = 4'h1,
    SEQ_WAIT = 4'h2,
    SEQ_ON   = 4'h4,
    SEQ_STOP = 4'h8
  } plro_seq_t;
  localparam logic EVT_PGOOD = 1'b0;
  localparam logic EVT_PDOWN = 1'b1;
endpackage : plro_pkg
`default_nettype wire

// ### plro_rail_peer.sv
// Peer rail model on the group bus, sending power events.
// Assumes the bench calls send() from its main thread.
`default_nettype none
module plro_rail_peer
(
  input  wire logic       clk_sys,
  output logic            evt,
  output logic            kind,
  output logic [4:0]      id
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Idle bus: never holds the last event fields
  initial
  begin
    evt  = 1'b0;
    kind = 1'b1;
    id   = 5'h1F;
  end
  // One event, one cycle wide, launched at a falling edge
  task automatic send(input logic k, input logic [4:0] i);
    @(negedge clk_sys);
    evt  = 1'b1;
    kind = k;
    id   = i;
    @(negedge clk_sys);
    evt  = 1'b0;
    kind = ~k;
    id   = ~i;
  endtask : send
endmodule : plro_rail_peer
`default_nettype wire

// ### pmbus_loop_and_rail_order_cmds_tb.sv
// Self-checking bench for the loop and rail order command bank.
// Assumes the bench acts as the PMBus framing host on clk_sys.
`default_nettype none
module pmbus_loop_and_rail_order_cmds_tb
  import plro_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Stimulus and observed signals
  logic               clk_sys, sys_rst, cmd_wr, cmd_rd, cmd_ack, cmd_unsupported;
  logic [7:0]         cmd_code;
  logic [31:0]        cmd_wdata, cmd_rdata;
  logic [15:0]        current_cal_gain, toff_cycles, fast_loop_gain;
  logic signed [11:0] temp_int, temp_ext0, temp_ext1;
  logic signed [23:0] sense_resistance0, sense_resistance1;
  logic               ext_sense_en, adapt_active, fast_loop_response_en, on_request, output_enable;
  logic [1:0]         adapt_inc, adapt_dec;
  logic signed [7:0]  gap_lh_ns, gap_hl_ns;
  logic [7:0]         fast_loop_residual;
  logic               group_comm_bus_evt, group_comm_bus_kind;
  logic [4:0]         group_comm_bus_id;
  int                 n_fail, checked, n;
  // ==========================================
  // Design and peer rail
  plro_cmds dut (.clk_sys, .sys_rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack,
    .cmd_unsupported, .current_cal_gain, .temp_int, .temp_ext0, .temp_ext1, .ext_sense_en,
    .sense_resistance0, .sense_resistance1, .adapt_active, .adapt_inc, .adapt_dec, .gap_lh_ns,
    .gap_hl_ns, .fast_loop_response_en, .fast_loop_residual, .fast_loop_gain, .on_request,
    .group_comm_bus_evt, .group_comm_bus_kind, .group_comm_bus_id, .toff_cycles, .output_enable);
  plro_rail_peer peer (.clk_sys(clk_sys), .evt(group_comm_bus_evt), .kind(group_comm_bus_kind),
    .id(group_comm_bus_id));
  // Free-running 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Verdict, compare and bus tasks
  task automatic close_out();
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    @(negedge clk_sys);
    cmd_wr    = 1'b1;
    cmd_code  = c;
    cmd_wdata = d;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
    chk("write ack", 32'h1, {31'h0, cmd_ack});
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [31:0] e);
    @(negedge clk_sys);
    cmd_rd   = 1'b1;
    cmd_code = c;
    @(negedge clk_sys);
    cmd_rd = 1'b0;
    chk("read data", e, cmd_rdata);
    chk("read ack", 32'h1, {31'h0, cmd_ack});
  endtask : rd
  // Bounded wait for the rail enable to reach a level
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (output_enable !== v && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (output_enable !== v)
    begin
      // Timed out: report as a mismatch, then end the run
      chk("output_enable", {31'h0, v}, {31'h0, output_enable});
      close_out();
    end
  endtask : wait_oe
  // Hold step requests for 30 cycles, then check both gaps
  task automatic steps(input logic [1:0] inc, input logic [1:0] dec, input logic [7:0] e);
    adapt_inc = inc;
    adapt_dec = dec;
    repeat (30) @(negedge clk_sys);
    adapt_inc = 2'h0;
    adapt_dec = 2'h0;
    @(negedge clk_sys);
    chk("gap_hl_ns", {24'h0, e}, {24'h0, gap_hl_ns});
    chk("gap_lh_ns", {24'h0, e}, {24'h0, gap_lh_ns});
  endtask : steps
  // ==========================================
  // Scenarios
  task automatic t_masks();
    logic [7:0]  codes [5];
    logic [31:0] msks [5];
    codes = '{CMD_TEMPCO, CMD_GAP, CMD_GAPMODE, CMD_LOOP, CMD_ORDER};
    msks  = '{MSK_TEMPCO, MSK_GAP, MSK_GAPMODE, MSK_LOOP, MSK_ORDER};
    rd(CMD_GAP, 32'h0000_3C3C);
    // Stepping up from 60 ns must stop at the default maximum
    adapt_active = 1'b1;
    steps(2'h3, 2'h0, 8'h3C);
    adapt_active = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(codes[i], 32'hFFFF_FFFF);
      rd(codes[i], msks[i]);
    end
    chk("loop fields", 32'h01FF_FFFF, {fast_loop_response_en, fast_loop_residual, fast_loop_gain});
    wr(CMD_LOOP, 32'h00A5_1234);
    chk("loop fields", 32'h00A5_1234, {fast_loop_response_en, fast_loop_residual, fast_loop_gain});
    cmd_rd   = 1'b1;
    cmd_code = 8'hE1;
    @(negedge clk_sys);
    cmd_rd = 1'b0;
    chk("unsupported", 32'h1, {31'h0, cmd_unsupported & ~cmd_ack});
    chk("read data", 32'h0, cmd_rdata);
  endtask : t_masks
  task automatic t_gap();
    wr(CMD_GAP, 32'h0000_05FB);
    // Applied gaps follow the stored word one cycle later
    @(negedge clk_sys);
    chk("fixed gaps", 32'h05FB, {16'h0, gap_hl_ns, gap_lh_ns});
    wr(CMD_GAP, 32'h0000_1414);
    wr(CMD_GAPMODE, 32'h0000_0000);
    adapt_active = 1'b1;
    // Down to the zero minimum, then up to the new 20 ns maximum
    steps(2'h0, 2'h3, 8'h00);
    steps(2'h3, 2'h0, 8'h14);
    wr(CMD_GAPMODE, 32'h0000_8080);
    steps(2'h0, 2'h3, 8'h14);
    wr(CMD_GAPMODE, 32'h0000_0202);
    steps(2'h0, 2'h3, 8'h04);
    wr(CMD_GAPMODE, 32'h0000_7B7B);
    steps(2'h0, 2'h3, 8'hF6);
    adapt_active = 1'b0;
    steps(2'h0, 2'h0, 8'h14);
  endtask : t_gap
  task automatic t_sense();
    wr(CMD_TEMPCO, 32'h0000_00B2);
    repeat (3) @(negedge clk_sys);
    chk("sense0", 32'h44C, {8'h0, sense_resistance0});
    chk("sense1", 32'h44C, {8'h0, sense_resistance1});
    ext_sense_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("sense0", 32'h320, {8'h0, sense_resistance0});
    chk("sense1", 32'h5DC, {8'h0, sense_resistance1});
    // Source bit cleared: internal sensor even with external sensing on
    wr(CMD_TEMPCO, 32'h0000_0032);
    repeat (3) @(negedge clk_sys);
    chk("sense0", 32'h44C, {8'h0, sense_resistance0});
    chk("sense1", 32'h44C, {8'h0, sense_resistance1});
  endtask : t_sense
  task automatic t_order();
    wr(CMD_ORDER, 32'h0000_8385);
    on_request = 1'b1;
    peer.send(EVT_PGOOD, 5'h04);
    repeat (4) @(negedge clk_sys);
    chk("held off", 32'h0, {31'h0, output_enable});
    peer.send(EVT_PGOOD, 5'h03);
    wait_oe(1'b1, 6);
    peer.send(EVT_PDOWN, 5'h06);
    repeat (4) @(negedge clk_sys);
    chk("still on", 32'h1, {31'h0, output_enable});
    peer.send(EVT_PDOWN, 5'h05);
    wait_oe(1'b0, 10);
    chk("sequel off edges", 32'd4, n);
    on_request = 1'b0;
    wr(CMD_ORDER, 32'h0000_0005);
    wait_oe(1'b0, 10);
    on_request = 1'b1;
    wait_oe(1'b1, 4);
    peer.send(EVT_PDOWN, 5'h05);
    repeat (6) @(negedge clk_sys);
    chk("sequel ignored", 32'h1, {31'h0, output_enable});
    on_request = 1'b0;
    wait_oe(1'b0, 10);
    chk("drop off edges", 32'd5, n);
  endtask : t_order
  // ==========================================
  // Main sequence
  initial
  begin
    {n_fail, checked, n} = '0;
    {sys_rst, cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {1'b1, 42'h0};
    {current_cal_gain, temp_int, temp_ext0, temp_ext1} = {16'h03E8, 12'h02D, 12'hFF1, 12'h07D};
    {ext_sense_en, adapt_active, adapt_inc, adapt_dec, on_request, toff_cycles} = {6'h0, 1'b0, 16'h0003};
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_masks();
    t_gap();
    t_sense();
    t_order();
    close_out();
  end
endmodule : pmbus_loop_and_rail_order_cmds_tb
`default_nettype wire
